/* bench/mic_core_model.sv */
// Purpose: core sequencer stand-in that takes requests and keeps a return count
// Assumes: one-cycle ack pulse, DEPTH return addresses fit on the stack
// Notes:   acks whenever asked, even when full; the controller must gate it
`timescale 1ns/10ps
module mic_core_model #(
  parameter int DEPTH = 2
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic irqReq,
  input  wire logic ackEn,
  input  wire logic retReq,
  output logic      irqAck,
  output logic      returnFromIrq,
  output logic      stackFull
);
  logic [3:0] depth_r;

  // full flag follows the return-address count
  assign stackFull = (depth_r == 4'(DEPTH));

  // one ack per pending request, pop only with something saved
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irqAck        <= 1'b0;
      returnFromIrq <= 1'b0;
      depth_r       <= 4'h0;
    end else begin
      irqAck        <= irqReq && ackEn && !irqAck;
      returnFromIrq <= retReq && (depth_r != 4'h0);
      if (irqAck && irqReq)
        depth_r <= depth_r + 4'h1;
      else if (returnFromIrq)
        depth_r <= depth_r - 4'h1;
    end
  end
endmodule

/* bench/mic_irq_ctrl_tb.sv */
// Purpose: self-checking bench for the interrupt controller
// Assumes: zero-wait register bus, core model acks when ackEn is high
// Notes:   driver queues expected results, a monitor pops and compares
`timescale 1ns/10ps
`include "mic_consts.svh"
module mic_irq_ctrl_tb;
  logic        ref_clk, rst, psel, penable, pwrite, lowPowerMode, ackEn, retReq;
  logic        pready, pslverr, stackFull, irqAck, returnFromIrq, irqReq, wakeUp;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, lfsr_r;
  logic [1:0]  extIrqPin, pinFuncSel, pinDirIn, mode;
  logic [3:0]  primaryEvt, irqIndex;
  logic [15:0] memberEvt;
  logic [11:0] irqVector;
  logic [32:0] rdQ[$];
  logic [11:0] vecQ[$];
  logic [11:0] vExp;
  logic [7:0]  masks[8] = '{8'h67, 8'hFF, 8'hFF, 8'h33, 8'hFF, 8'h77, 8'h33, 8'h0F};
  int          idxTab[8] = '{2, 5, 7, 8, 3, 4, 6, 9};
  int          failures, num_checks, wakes, w0;

  mic_irq_ctrl u_dut (.ref_clk(ref_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .extIrqPin(extIrqPin), .pinFuncSel(pinFuncSel), .pinDirIn(pinDirIn), .primaryEvt(primaryEvt),
    .memberEvt(memberEvt), .stackFull(stackFull), .irqAck(irqAck), .returnFromIrq(returnFromIrq),
    .lowPowerMode(lowPowerMode), .irqReq(irqReq), .irqVector(irqVector), .irqIndex(irqIndex),
    .wakeUp(wakeUp));

  mic_core_model u_core (.ref_clk(ref_clk), .rst(rst), .irqReq(irqReq), .ackEn(ackEn),
    .retReq(retReq), .irqAck(irqAck), .returnFromIrq(returnFromIrq), .stackFull(stackFull));

  // free-running 50 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic chk_rd(input logic [32:0] e, input logic [32:0] s);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("[ERR] read data exp %h seen %h", e, s);
    end
  endtask

  task automatic chk_vec(input logic [11:0] e, input logic [11:0] s);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("[ERR] irqVector exp %h seen %h", e, s);
    end
  endtask

  task automatic chk_idx(input logic [3:0] e, input logic [3:0] s);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("[ERR] irqIndex exp %h seen %h", e, s);
    end
  endtask

  task automatic chk_cnt(input int e, input int s);
    num_checks++;
    if (s != e) begin
      failures++;
      $display("[ERR] wake count exp %0d seen %0d", e, s);
    end
  endtask

  // monitor: results taken at the edge the handshake completes
  always @(posedge ref_clk) begin
    if (psel && penable && pready && !pwrite)
      chk_rd(rdQ.size() ? rdQ.pop_front() : 33'hX, {pslverr, prdata});
    // index follows from the vector: base 4, step 4
    if (irqAck && irqReq) begin
      vExp = vecQ.size() ? vecQ.pop_front() : 12'hXXX;
      chk_vec(vExp, irqVector);
      chk_idx(4'((vExp - 12'h004) >> 2), irqIndex);
    end
    if (wakeUp)
      wakes++;
  end

  // one bus transfer; idle cycle after it so no signal is driven twice in a step
  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d, input logic e);
    if (!w)
      rdQ.push_back({e, 24'h0, d});
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    // no local limit: a missing pready is caught by the watchdog
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(a, 1'b1, d, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d);
    apb(a, 1'b0, d, 1'b0);
  endtask

  task automatic ev(input logic [3:0] p, input logic [15:0] m);
    primaryEvt <= p;
    memberEvt  <= m;
    @(posedge ref_clk);
    primaryEvt <= 4'h0;
    memberEvt  <= 16'h0;
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic ret();
    retReq <= 1'b1;
    @(posedge ref_clk);
    retReq <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask

  // bounded wait for queued acks; late or missing ones count as mismatches
  task automatic settle();
    int n;
    n = 0;
    while (vecQ.size() != 0 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    repeat (3) @(posedge ref_clk);
    if (vecQ.size() != 0) begin
      num_checks++;
      failures++;
      $display("[ERR] irqVector exp %h seen none", vecQ[0]);
      vecQ.delete();
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watchdog well beyond the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    end_sim();
  end

  // main sequence
  initial begin
    {rst, psel, penable, pwrite, lowPowerMode, ackEn, retReq} = 7'h40;
    {paddr, pwdata, extIrqPin, pinFuncSel, pinDirIn, primaryEvt, memberEvt} = '0;
    lfsr_r = 32'h9B4C73C0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    foreach (masks[i]) rd(8'(i * 4), 8'h00);
    apb(8'h24, 1'b0, 8'h00, 1'b1);
    apb(8'h02, 1'b0, 8'h00, 1'b1);
    foreach (masks[i]) wr(8'(i * 4), 8'hFF);
    foreach (masks[i]) rd(8'(i * 4), masks[i]);
    foreach (masks[i]) wr(8'(i * 4), 8'h00);
    repeat (4) begin
      lfsr_r = nxt(lfsr_r);
      wr(`MIC_OFF_EDGE, lfsr_r[7:0]);
      rd(`MIC_OFF_EDGE, lfsr_r[7:0] & 8'h0F);
    end
    $display("test registers done");
    wr(`MIC_OFF_PRIM_B, 8'h0F);
    wr(`MIC_OFF_PRIM_C, 8'h0F);
    ackEn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      wr(`MIC_OFF_CORE, 8'h01);
      vecQ.push_back(12'(4 + 4 * idxTab[i]));
      ev(i < 4 ? 4'(1 << i) : 4'h0, i < 4 ? 16'h0 : 16'(1 << (4 * (i - 4))));
      settle();
      rd(`MIC_OFF_CORE, 8'h00);
      rd(`MIC_OFF_PRIM_B, 8'h0F);
      rd(`MIC_OFF_PRIM_C, 8'h0F);
      if (i >= 4) begin
        rd(8'(12 + 4 * (i - 4)), 8'h10);
        wr(8'(12 + 4 * (i - 4)), 8'h00);
      end
      ret();
    end
    $display("test sources done");
    ev(4'h3, 16'h0);
    settle();
    rd(`MIC_OFF_PRIM_B, 8'h9F);
    vecQ.push_back(12'h00C);
    wr(`MIC_OFF_CORE, 8'h01);
    settle();
    vecQ.push_back(12'h018);
    wr(`MIC_OFF_CORE, 8'h01);
    settle();
    ev(4'h1, 16'h0);
    wr(`MIC_OFF_CORE, 8'h01);
    settle();
    vecQ.push_back(12'h00C);
    ret();
    settle();
    ret();
    ret();
    wr(`MIC_OFF_PRIM_B, 8'h00);
    wr(`MIC_OFF_CORE, 8'h01);
    ev(4'h1, 16'h0);
    settle();
    rd(`MIC_OFF_PRIM_B, 8'h80);
    vecQ.push_back(12'h00C);
    wr(`MIC_OFF_PRIM_B, 8'h88);
    settle();
    ret();
    rd(`MIC_OFF_STAT, 8'h02);
    $display("test priority and stack done");
    ackEn <= 1'b0;
    // both pins move together; last pass blocks pin 0 by direction, pin 1 by function
    for (int m = 0; m < 5; m++) begin
      mode = (m == 4) ? 2'h3 : 2'(m);
      pinDirIn   <= {1'b1, m < 4};
      pinFuncSel <= {m < 4, 1'b1};
      wr(`MIC_OFF_EDGE, {4'h0, mode, mode});
      wr(`MIC_OFF_CORE, 8'h06);
      extIrqPin <= 2'b11;
      repeat (2) @(posedge ref_clk);
      rd(`MIC_OFF_CORE, {1'b0, {2{(m < 4) && mode[0]}}, 5'h06});
      wr(`MIC_OFF_CORE, 8'h06);
      extIrqPin <= 2'b00;
      repeat (2) @(posedge ref_clk);
      rd(`MIC_OFF_CORE, {1'b0, {2{(m < 4) && mode[1]}}, 5'h06});
    end
    // serviced pin request: flag and global enable drop, pin enable stays
    pinDirIn   <= 2'b11;
    pinFuncSel <= 2'b11;
    ackEn      <= 1'b1;
    wr(`MIC_OFF_EDGE, 8'h01);
    wr(`MIC_OFF_CORE, 8'h03);
    vecQ.push_back(12'h004);
    extIrqPin <= 2'b01;
    settle();
    rd(`MIC_OFF_CORE, 8'h02);
    ret();
    $display("test pins done");
    wr(`MIC_OFF_CORE, 8'h00);
    wr(`MIC_OFF_PRIM_B, 8'h80);
    lowPowerMode <= 1'b1;
    @(posedge ref_clk);
    w0 = wakes;
    ev(4'h1, 16'h0);
    chk_cnt(0, wakes - w0);
    ev(4'h2, 16'h0);
    chk_cnt(1, wakes - w0);
    lowPowerMode <= 1'b0;
    $display("test wake done");
    end_sim();
  end
endmodule

/* design/mic_edge_detect.sv */
// Purpose: edge detection on the two external request pins
// Assumes: pins synchronous to clk; arm already qualifies pin function
// Notes:   first cycle after reset never reports an edge
`timescale 1ns/10ps
module mic_edge_detect (
  input wire logic clk,
  input wire logic rst,
  mic_ext_if.det   ext
);
  logic [1:0] prev_r;
  logic [1:0] prev_nxt;
  logic       primed_r;
  logic       primed_nxt;
  logic [1:0] hit;

  // edge match per pin from its two-bit mode
  always_comb begin
    prev_nxt   = ext.pin;
    primed_nxt = 1'b1;
    for (int i = 0; i < 2; i++) begin
      unique case (mic_pkg::mic_edge_t'(ext.sel[2*i +: 2])) // R14
        mic_pkg::MIC_EDGE_OFF:  hit[i] = 1'b0;
        mic_pkg::MIC_EDGE_RISE: hit[i] = ext.pin[i] & ~prev_r[i];
        mic_pkg::MIC_EDGE_FALL: hit[i] = ~ext.pin[i] & prev_r[i];
        mic_pkg::MIC_EDGE_BOTH: hit[i] = ext.pin[i] ^ prev_r[i];
      endcase
    end
  end

  // unprimed history would fake an edge on a pin held high at reset
  assign ext.evt = hit & ext.arm & {2{primed_r}}; // R13

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_r   <= 2'h0;
      primed_r <= 1'b0;
    end else begin
      prev_r   <= prev_nxt;
      primed_r <= primed_nxt;
    end
  end

  property p_fall_pin1;
    @(posedge clk) disable iff (rst)
      (ext.sel[3:2] == 2'h2 && ext.arm[1] && primed_r && $fell(ext.pin[1])) |-> ext.evt[1];
  endproperty
  a_fall_pin1: assert property (p_fall_pin1) else $error("falling edge on pin 1 missed"); // R14

  property p_off_silent;
    @(posedge clk) disable iff (rst)
      (ext.sel[1:0] == 2'h0 || !ext.arm[0]) |-> !ext.evt[0];
  endproperty
  a_off_silent: assert property (p_off_silent) else $error("pin 0 event while disabled"); // R15
endmodule

/* design/mic_irq_ctrl.sv */
// Purpose: interrupt flags, enables, priority pick and vectoring for the core
// Assumes: APB master per protocol; core pulses irqAck when it takes a request
// Notes:   zero-wait APB slave; read data is captured in the setup cycle
//
// Summary of operation
// R1 - a source event sets its request flag; flags reset to zero
// R2 - a flag with enable low stays set but raises no request
// R3 - global enable low suppresses every request
// R4 - taking a request pushes the return address and loads the source vector
// R5 - return from interrupt pops the saved address and resumes
// R6 - servicing clears the global enable automatically
// R7 - events during service still set their flags
// R8 - software may set the global enable again inside a service routine
// R9 - no request is acknowledged while the stack is full
// R10 - simultaneous enabled requests are resolved by fixed priority
// R11 - priority order and vector addresses are design parameters
// R12 - a newly set flag wakes the part; flags already set do not
// R13 - external flag sets on the edge chosen by its select field
// R14 - edge codes: 00 off, 01 rising, 10 falling, 11 both
// R15 - pin acts as interrupt only if enabled, selected and an input
// R16 - servicing an external request clears its flag; pull-ups unaffected
// R17 - group flag sets when a member sets; service clears only the group flag
// R18 - second primary register: flags converter, group1, group0, serial; enables below
// R19 - third primary register: flags group3, timebase1, timebase0, group2; enables below
// R20 - group register 0: compact timer0 A/P flags bits 5,4, enables 1,0
// R21 - group register 1: standard timer A/P, compact timer1 A/P, enables below
// R22 - group register 2: serial-if bit 6, periodic A/P bits 5,4, enables 2..0
// R23 - group register 3: memory-write bit 5, low-volt bit 4, enables 1,0
`timescale 1ns/10ps
`include "mic_consts.svh"
module mic_irq_ctrl #(
  parameter int                 PCW        = 12,
  parameter int                 VEC_BASE   = 4,
  parameter int                 VEC_STEP   = 4,
  parameter int                 DEPTH_W    = 4,
  parameter logic [9:0][3:0]    PRIO_ORDER = {4'h9, 4'h8, 4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0}
) (
  input  wire logic            ref_clk,
  input  wire logic            rst,
  input  wire logic [7:0]      paddr,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic [1:0]      extIrqPin,
  input  wire logic [1:0]      pinFuncSel,
  input  wire logic [1:0]      pinDirIn,
  input  wire logic [3:0]      primaryEvt,
  input  wire logic [15:0]     memberEvt,
  input  wire logic            stackFull,
  input  wire logic            irqAck,
  input  wire logic            returnFromIrq,
  input  wire logic            lowPowerMode,
  output logic                 irqReq,
  output logic      [PCW-1:0]  irqVector,
  output logic      [3:0]      irqIndex,
  output logic                 wakeUp
);
  localparam int NSRC = `MIC_NUM_SRC;
  // source order: ext0, ext1, converter, group0, group1, serial, group2, tb0, tb1, group3
  localparam int SRC_REG [NSRC] = '{0, 0, 1, 1, 1, 1, 2, 2, 2, 2};
  localparam int SRC_BIT [NSRC] = '{5, 6, 7, 5, 6, 4, 4, 5, 6, 7};

  // refuse shapes the vector, depth and index logic cannot hold
  if (PCW < 4 || PCW > 16) begin : g_bad_pcw
    $error("PCW must lie between 4 and 16");
  end
  if (DEPTH_W < 1 || DEPTH_W > 8) begin : g_bad_depth
    $error("DEPTH_W must lie between 1 and 8");
  end
  for (genvar g = 0; g < NSRC; g++) begin : g_chk_prio
    if (PRIO_ORDER[g] >= NSRC) begin : g_bad_prio
      $error("PRIO_ORDER entry out of range");
    end
  end

  mic_pkg::mic_bank_t  irq_r;
  mic_pkg::mic_bank_t  irq_nxt;
  logic [3:0]          edge_r;
  logic [3:0]          edge_nxt;
  logic [DEPTH_W-1:0]  depth_r;
  logic [DEPTH_W-1:0]  depth_nxt;
  logic                irqReq_r;
  logic                irqReq_nxt;
  logic [3:0]          irqIdx_r;
  logic [3:0]          irqIdx_nxt;
  logic [PCW-1:0]      irqVec_r;
  logic [PCW-1:0]      irqVec_nxt;
  logic                wakeUp_r;
  logic                wakeUp_nxt;
  logic [31:0]         prdata_r;
  logic [31:0]         prdata_nxt;
  logic                pready_r;
  logic                pready_nxt;
  logic                pslverr_r;
  logic                pslverr_nxt;
  logic                apbSetup;
  logic                apbWrite;
  logic                addrOk;
  logic [3:0]          apbIdx;
  logic                ackTake;
  logic [3:0]          grpRise;
  logic [7:0]          anyRise;
  logic [NSRC-1:0]     pendNow;
  logic [NSRC-1:0]     pendNxt;
  logic                pickFound;
  logic [3:0]          pickIdx;

  mic_ext_if extBus ();

  // implemented bits of each bank register
  function automatic logic [7:0] regMask(input int idx);
    unique case (idx)
      0:       regMask = `MIC_MASK_CORE;
      3:       regMask = `MIC_MASK_GRP0;
      4:       regMask = `MIC_MASK_GRP1;
      5:       regMask = `MIC_MASK_GRP2;
      6:       regMask = `MIC_MASK_GRP3;
      default: regMask = `MIC_MASK_PRIM;
    endcase
  endfunction

  // flag at bit n+4 pairs with its enable at bit n
  function automatic logic [NSRC-1:0] pendOf(input mic_pkg::mic_bank_t bank);
    for (int i = 0; i < NSRC; i++) begin
      pendOf[i] = bank[SRC_REG[i]][SRC_BIT[i]] & bank[SRC_REG[i]][SRC_BIT[i] - `MIC_FLAG_LSB]; // R2
    end
  endfunction

  // first pending source in parameter order wins
  function automatic logic [4:0] pickOf(input logic [NSRC-1:0] pend);
    pickOf = 5'h00;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pend[PRIO_ORDER[i]]) begin
        pickOf = {1'b1, PRIO_ORDER[i]}; // R10 R11
      end
    end
  endfunction

  // pin qualification: enable, pin function and input direction together
  assign extBus.pin = extIrqPin;
  assign extBus.sel = edge_r;
  assign extBus.arm = {irq_r[0][2], irq_r[0][1]} & pinFuncSel & pinDirIn; // R15

  mic_edge_detect u_edge (
    .clk (ref_clk),
    .rst (rst),
    .ext (extBus)
  );

  // bus decode; offsets step by one word
  assign apbSetup = psel & ~penable;
  assign apbWrite = psel & penable & pready_r & pwrite;
  assign addrOk   = (paddr[1:0] == 2'h0) && (paddr <= `MIC_OFF_STAT);
  assign apbIdx   = paddr[5:2];
  assign ackTake  = irqAck & irqReq_r;
  assign pendNow  = pendOf(irq_r);

  // flag and enable bank: write, then auto clear, then hardware set
  always_comb begin
    irq_nxt  = irq_r;
    edge_nxt = edge_r;
    if (apbWrite && addrOk) begin
      if (apbIdx < 4'(`MIC_NUM_REG)) begin
        irq_nxt[apbIdx[2:0]] = pwdata[7:0] & regMask(int'(apbIdx)); // R8 R18 R19 R20 R21 R22 R23
      end else if (paddr == `MIC_OFF_EDGE) begin
        edge_nxt = pwdata[3:0];
      end
    end
    // service entry: the chosen flag and the global enable drop
    if (ackTake) begin
      irq_nxt[0][`MIC_BIT_GIE] = 1'b0; // R6
      for (int i = 0; i < NSRC; i++) begin
        if (irqIdx_r == 4'(i)) begin
          irq_nxt[SRC_REG[i]][SRC_BIT[i]] = 1'b0; // R16 R17
        end
      end
    end
    // hardware sets last so an event never loses to a clear
    irq_nxt[0][`MIC_BIT_EXT0F] = irq_nxt[0][`MIC_BIT_EXT0F] | extBus.evt[0]; // R13
    irq_nxt[0][`MIC_BIT_EXT1F] = irq_nxt[0][`MIC_BIT_EXT1F] | extBus.evt[1]; // R13
    irq_nxt[1][7] = irq_nxt[1][7] | primaryEvt[0]; // R1 R7
    irq_nxt[1][4] = irq_nxt[1][4] | primaryEvt[1]; // R1
    irq_nxt[2][5] = irq_nxt[2][5] | primaryEvt[2]; // R1
    irq_nxt[2][6] = irq_nxt[2][6] | primaryEvt[3]; // R1
    for (int g = 0; g < 4; g++) begin
      irq_nxt[3 + g] = irq_nxt[3 + g] | ({memberEvt[4*g +: 4], 4'h0} & regMask(3 + g)); // R1
      grpRise[g] = |(irq_nxt[3 + g] & ~irq_r[3 + g] & `MIC_MASK_FLAGS);
    end
    // member flags stay set; only the group flag is serviced
    irq_nxt[1][5] = irq_nxt[1][5] | grpRise[0]; // R17
    irq_nxt[1][6] = irq_nxt[1][6] | grpRise[1]; // R17
    irq_nxt[2][4] = irq_nxt[2][4] | grpRise[2]; // R17
    irq_nxt[2][7] = irq_nxt[2][7] | grpRise[3]; // R17
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_r  <= {`MIC_NUM_REG{`MIC_RESET_BYTE}};
      edge_r <= 4'h0;
    end else begin
      irq_r  <= irq_nxt;
      edge_r <= edge_nxt;
    end
  end

  // request, vector and wake; built from next state so no stale request follows an ack
  always_comb begin
    pendNxt              = pendOf(irq_nxt);
    {pickFound, pickIdx} = pickOf(pendNxt);
    irqReq_nxt = irq_nxt[0][`MIC_BIT_GIE] & pickFound & ~stackFull; // R3 R9
    irqIdx_nxt = pickFound ? pickIdx : irqIdx_r;
    irqVec_nxt = PCW'(VEC_BASE + int'(irqIdx_nxt) * VEC_STEP); // R4 R11
    for (int r = 0; r < `MIC_NUM_REG; r++) begin
      anyRise[r] = |(irq_nxt[r] & ~irq_r[r] & `MIC_MASK_FLAGS);
    end
    anyRise[7] = 1'b0;
    // a flag set before sleep shows no rise, so it cannot wake
    wakeUp_nxt = lowPowerMode & (|anyRise); // R12
  end

  // nesting depth mirrors the core stack: push on ack, pop on return
  always_comb begin
    depth_nxt = depth_r;
    if (ackTake && !returnFromIrq && depth_r != {DEPTH_W{1'b1}}) begin
      depth_nxt = depth_r + 1'b1; // R4
    end else if (returnFromIrq && !ackTake && depth_r != '0) begin
      depth_nxt = depth_r - 1'b1; // R5
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irqReq_r <= 1'b0;
      irqIdx_r <= 4'h0;
      irqVec_r <= '0;
      wakeUp_r <= 1'b0;
      depth_r  <= '0;
    end else begin
      irqReq_r <= irqReq_nxt;
      irqIdx_r <= irqIdx_nxt;
      irqVec_r <= irqVec_nxt;
      wakeUp_r <= wakeUp_nxt;
      depth_r  <= depth_nxt;
    end
  end

  // bus answer: zero wait, data and error settled during setup
  always_comb begin
    pready_nxt  = apbSetup;
    pslverr_nxt = apbSetup & ~addrOk;
    prdata_nxt  = prdata_r;
    if (apbSetup) begin
      prdata_nxt = 32'h0000_0000;
      if (addrOk && apbIdx < 4'(`MIC_NUM_REG)) begin
        prdata_nxt[7:0] = irq_r[apbIdx[2:0]];
      end else if (addrOk && paddr == `MIC_OFF_EDGE) begin
        prdata_nxt[3:0] = edge_r;
      end else if (addrOk) begin
        prdata_nxt[3:0] = irqIdx_r;
        prdata_nxt[4]   = irqReq_r;
        prdata_nxt[8 +: DEPTH_W] = depth_r;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata    = prdata_r;
  assign pready    = pready_r;
  assign pslverr   = pslverr_r;
  assign irqReq    = irqReq_r;
  assign irqVector = irqVec_r;
  assign irqIndex  = irqIdx_r;
  assign wakeUp    = wakeUp_r;

  property p_gie_gates;
    @(posedge ref_clk) disable iff (rst)
      irqReq_r |-> irq_r[0][`MIC_BIT_GIE];
  endproperty
  a_gie_gates: assert property (p_gie_gates) else $error("request with global enable low"); // R3

  property p_stack_full;
    @(posedge ref_clk) disable iff (rst)
      stackFull |=> !irqReq_r;
  endproperty
  a_stack_full: assert property (p_stack_full) else $error("request while stack full"); // R9

  property p_ack_clears_gie;
    @(posedge ref_clk) disable iff (rst)
      ackTake |=> !irq_r[0][`MIC_BIT_GIE] && !irqReq_r;
  endproperty
  a_ack_clears_gie: assert property (p_ack_clears_gie) else $error("global enable kept after ack"); // R6

  property p_conv_sets;
    @(posedge ref_clk) disable iff (rst)
      primaryEvt[0] |=> irq_r[1][7];
  endproperty
  a_conv_sets: assert property (p_conv_sets) else $error("converter event lost"); // R1

  property p_req_enabled;
    @(posedge ref_clk) disable iff (rst)
      irqReq_r |-> pendNow[irqIdx_r];
  endproperty
  a_req_enabled: assert property (p_req_enabled) else $error("request for disabled source"); // R2

  property p_ext0_cleared;
    @(posedge ref_clk) disable iff (rst)
      (ackTake && irqIdx_r == 4'h0 && !extBus.evt[0]) |=> !irq_r[0][`MIC_BIT_EXT0F];
  endproperty
  a_ext0_cleared: assert property (p_ext0_cleared) else $error("pin 0 flag survived service"); // R16

  property p_group1_sets;
    @(posedge ref_clk) disable iff (rst)
      (memberEvt[4] && !irq_r[4][4]) |=> irq_r[1][6] && irq_r[4][4];
  endproperty
  a_group1_sets: assert property (p_group1_sets) else $error("group 1 flag not raised"); // R17

  property p_wake;
    @(posedge ref_clk) disable iff (rst)
      (lowPowerMode && primaryEvt[1] && !irq_r[1][4]) |=> wakeUp_r;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on new flag"); // R12

  property p_pop;
    @(posedge ref_clk) disable iff (rst)
      (returnFromIrq && !ackTake && depth_r != '0) |=> depth_r == $past(depth_r) - 1'b1;
  endproperty
  a_pop: assert property (p_pop) else $error("return did not pop depth"); // R5
endmodule

/* pkg/mic_consts.svh */
// Purpose: register offsets, masks, field positions and reset values
// Assumes: byte addresses on a 32-bit register bus, one word per register
// Notes:   included by every design file that decodes the register map
`ifndef MIC_CONSTS_SVH
`define MIC_CONSTS_SVH

`define MIC_OFF_CORE   8'h00
`define MIC_OFF_PRIM_B 8'h04
`define MIC_OFF_PRIM_C 8'h08
`define MIC_OFF_GRP0   8'h0C
`define MIC_OFF_GRP1   8'h10
`define MIC_OFF_GRP2   8'h14
`define MIC_OFF_GRP3   8'h18
`define MIC_OFF_EDGE   8'h1C
`define MIC_OFF_STAT   8'h20

`define MIC_MASK_CORE  8'h67
`define MIC_MASK_PRIM  8'hFF
`define MIC_MASK_GRP0  8'h33
`define MIC_MASK_GRP1  8'hFF
`define MIC_MASK_GRP2  8'h77
`define MIC_MASK_GRP3  8'h33
`define MIC_MASK_EDGE  8'h0F
`define MIC_MASK_FLAGS 8'hF0

`define MIC_RESET_BYTE 8'h00
`define MIC_BIT_GIE    0
`define MIC_BIT_EXT0F  5
`define MIC_BIT_EXT1F  6
`define MIC_FLAG_LSB   4
`define MIC_NUM_SRC    10
`define MIC_NUM_REG    7

`endif

/* pkg/mic_ext_if.sv */
// Purpose: carries external pin levels, edge modes and detected events
// Assumes: pins already synchronous to ref_clk
// Notes:   ctrl side is the controller, det side the edge detector
`timescale 1ns/10ps
interface mic_ext_if;
  logic [1:0] pin;
  logic [3:0] sel;
  logic [1:0] arm;
  logic [1:0] evt;
  modport ctrl (output pin, output sel, output arm, input evt);
  modport det  (input pin, input sel, input arm, output evt);
endinterface

/* pkg/mic_pkg.sv */
// Purpose: shared types of the interrupt controller
// Assumes: constants live in mic_consts.svh
// Notes:   bank index 0 core, 1..2 primary, 3..6 group registers
package mic_pkg;
  typedef logic [6:0][7:0] mic_bank_t;
  typedef enum logic [1:0] {
    MIC_EDGE_OFF  = 2'h0,
    MIC_EDGE_RISE = 2'h1,
    MIC_EDGE_FALL = 2'h2,
    MIC_EDGE_BOTH = 2'h3
  } mic_edge_t;
endpackage
